// ### verilog/light_regs_pkg.sv
package light_regs_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  localparam logic [3:0] OFF_SECOND_LOW   = 4'h3;
  localparam logic [3:0] OFF_Q_FIRST_HIGH = 4'h4;
  localparam logic [3:0] OFF_Q_FIRST_LOW  = 4'h5;
  localparam logic [3:0] OFF_Q_SECOND_HIGH = 4'h6;
  localparam logic [3:0] OFF_Q_SECOND_LOW = 4'h7;
  localparam logic [3:0] OFF_LOW_LIMIT    = 4'h8;
  localparam logic [3:0] OFF_HIGH_LIMIT   = 4'h9;

  localparam int RANGE_LSB   = 12;
  localparam int HIGH_MSB    = 11;
  localparam int LOW_LSB     = 8;
  localparam int COUNT_LSB   = 4;
  localparam int CHECK_LSB   = 0;
  localparam int MANT_SHIFT  = 8;

  localparam logic [15:0] LOW_LIMIT_RST  = 16'h0000;
  localparam logic [15:0] HIGH_LIMIT_RST = 16'hBFFF;
  localparam logic [15:0] RESULT_RST     = 16'h0000;

  typedef struct packed {
    logic [3:0]  range_code;
    logic [19:0] mantissa;
    logic [3:0]  sample_count;
    logic [3:0]  check_code;
  } sample_t;

  typedef struct packed {
    logic [15:0] high_word;
    logic [15:0] low_word;
  } word_pair_t;

endpackage

// ### verilog/sample_bus_if.sv
`timescale 1ns/1ps
interface sample_bus_if;
  logic                    valid;
  light_regs_pkg::sample_t sample;
  modport src (output valid, output sample);
  modport dst (input  valid, input  sample);
endinterface

// ### verilog/sample_stamp.sv
`timescale 1ns/1ps
module sample_stamp (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        done_i,
  input  wire logic [3:0]  range_i,
  input  wire logic [11:0] high_i,
  input  wire logic [7:0]  low_i,
  sample_bus_if.src        out
);

  typedef struct packed {
    logic [3:0]              count;
    logic                    valid;
    light_regs_pkg::sample_t sample;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic [3:0] check_of(input logic [3:0]  e,
                                          input logic [19:0] r,
                                          input logic [3:0]  c);
    logic [3:0] x;
    x = 4'h0;
    // (RULE4) Full parity.
    x[0] = ^{e, r, c};
    // (RULE5) Odd bits.
    x[1] = c[1] ^ c[3] ^ r[1] ^ r[3] ^ r[5] ^ r[7] ^ r[9] ^ r[11] ^
           r[13] ^ r[15] ^ r[17] ^ r[19] ^ e[1] ^ e[3];
    // (RULE6) Every fourth.
    x[2] = c[3] ^ r[3] ^ r[7] ^ r[11] ^ r[15] ^ r[19] ^ e[3];
    // (RULE7) Every eighth.
    x[3] = r[3] ^ r[11] ^ r[19];
    return x;
  endfunction

  always_comb begin
    logic [19:0] m;
    logic [3:0]  c;
    m = 20'h00000;
    c = 4'h0;
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    if (done_i) begin
      // (RULE3) Mantissa combine.
      m = (20'(high_i) << light_regs_pkg::MANT_SHIFT) + 20'(low_i);
      // (RULE2) Rolling counter.
      c = s_r.count + 4'h1;
      s_nxt.count = c;
      s_nxt.valid = 1'b1;
      // (RULE16) Consistent entry.
      s_nxt.sample.range_code   = range_i;
      s_nxt.sample.mantissa     = m;
      s_nxt.sample.sample_count = s_r.count;
      s_nxt.sample.check_code   = check_of(range_i, m, s_r.count);
    end
  end

  // The first sample carries count zero; the counter then advances.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign out.valid  = s_r.valid & ce_i;
  assign out.sample = s_r.sample;

endmodule

// ### verilog/light_result_fifo_threshold_regs.sv
`timescale 1ns/1ps
// How it works
// (RULE1) Second-channel low mantissa byte in bits 15-8, read-only, reset zero.
// (RULE2) Four-bit per-channel counter in bits 7-4, increments per conversion.
// (RULE3) Mantissa equals high field shifted left eight plus low field.
// (RULE4) Check bit 0 is XOR of all exponent, mantissa, counter bits.
// (RULE5) Check bit 1 XORs counter 1,3, odd mantissa, exponent 1,3.
// (RULE6) Check bit 2 XORs counter 3, mantissa 3,7,11,15,19, exponent 3.
// (RULE7) Check bit 3 XORs mantissa 3,11,19; check sits in bits 3-0.
// (RULE8) Queued first exponent bits 15-12, high mantissa bits 11-0.
// (RULE9) Queued first low byte, counter, check in 15-8, 7-4, 3-0.
// (RULE10) Queued second exponent bits 15-12, high mantissa bits 11-0.
// (RULE11) Queued second low byte, counter, check in 15-8, 7-4, 3-0.
// (RULE12) Writable low limit, exponent and result, reset zero.
// (RULE13) Writable high limit, exponent resets B, result resets FFF.
// (RULE14) Exponent chooses full-scale range, scaling the mantissa.
// (RULE15) Channel select bit picks compared channel, 0 first, 1 second.
// (RULE16) Each conversion updates all fields of one entry together.
// (RULE17) Writes to read-only words are ignored.
module light_result_fifo_threshold_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        first_done_i,
  input  wire logic [3:0]  first_range_i,
  input  wire logic [11:0] first_high_i,
  input  wire logic [7:0]  first_low_i,
  input  wire logic        second_done_i,
  input  wire logic [3:0]  second_range_i,
  input  wire logic [11:0] second_high_i,
  input  wire logic [7:0]  second_low_i,
  input  wire logic        limit_channel_select_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  output logic      [15:0] low_limit_o,
  output logic      [15:0] high_limit_o,
  output logic      [3:0]  compare_range_o,
  output logic      [19:0] compare_mantissa_o
);

  typedef struct packed {
    light_regs_pkg::word_pair_t second_live;
    light_regs_pkg::word_pair_t q_first;
    light_regs_pkg::word_pair_t q_second;
    logic [15:0]                low_limit;
    logic [15:0]                high_limit;
    logic [15:0]                rdata;
    logic                       rvalid;
    logic [3:0]                 cmp_range;
    logic [19:0]                cmp_mant;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // The word layout is fixed by the package. A package edit that moves the
  // range field off the high mantissa, the counter off the check code, or the
  // low byte off the mantissa shift is refused here, because the packing
  // function below would otherwise drop bits without a warning.
  if (light_regs_pkg::DATA_W != 16) begin : g_bad_width
    $error("register words must be sixteen bits wide");
  end
  if (light_regs_pkg::RANGE_LSB != light_regs_pkg::HIGH_MSB + 1) begin : g_bad_range
    $error("range field must sit directly above the high mantissa");
  end
  if (light_regs_pkg::LOW_LSB != light_regs_pkg::MANT_SHIFT) begin : g_bad_low
    $error("low mantissa byte must be as wide as the mantissa shift");
  end
  if (light_regs_pkg::COUNT_LSB != light_regs_pkg::CHECK_LSB + 4) begin : g_bad_count
    $error("counter field must sit directly above the check code");
  end

  sample_bus_if first_bus ();
  sample_bus_if second_bus ();

  sample_stamp u_first (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .done_i  (first_done_i),
    .range_i (first_range_i),
    .high_i  (first_high_i),
    .low_i   (first_low_i),
    .out     (first_bus.src)
  );

  sample_stamp u_second (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .done_i  (second_done_i),
    .range_i (second_range_i),
    .high_i  (second_high_i),
    .low_i   (second_low_i),
    .out     (second_bus.src)
  );

  function automatic light_regs_pkg::word_pair_t pack_sample(
      input light_regs_pkg::sample_t smp);
    light_regs_pkg::word_pair_t w;
    w = '0;
    w.high_word[15:light_regs_pkg::RANGE_LSB] = smp.range_code;
    w.high_word[light_regs_pkg::HIGH_MSB:0] =
      smp.mantissa[19:light_regs_pkg::MANT_SHIFT];
    w.low_word[15:light_regs_pkg::LOW_LSB] =
      smp.mantissa[light_regs_pkg::MANT_SHIFT-1:0];
    w.low_word[light_regs_pkg::LOW_LSB-1:light_regs_pkg::COUNT_LSB] =
      smp.sample_count;
    w.low_word[light_regs_pkg::COUNT_LSB-1:light_regs_pkg::CHECK_LSB] =
      smp.check_code;
    return w;
  endfunction

  always_comb begin
    light_regs_pkg::word_pair_t sel;
    sel = '0;
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;

    // (RULE16) Whole-entry update.
    if (first_bus.valid) begin
      // (RULE8) First queue high.
      // (RULE9) First queue low.
      s_nxt.q_first = pack_sample(first_bus.sample);
    end
    if (second_bus.valid) begin
      // (RULE1) Live second low.
      s_nxt.second_live = pack_sample(second_bus.sample);
      // (RULE10) Second queue high.
      // (RULE11) Second queue low.
      s_nxt.q_second = pack_sample(second_bus.sample);
    end

    // (RULE12) Low limit write.
    // (RULE13) High limit write.
    // (RULE17) Read-only ignored.
    if (reg_wr_i) begin
      case (reg_addr_i)
        light_regs_pkg::OFF_LOW_LIMIT: begin
          s_nxt.low_limit = reg_wdata_i;
        end
        light_regs_pkg::OFF_HIGH_LIMIT: begin
          s_nxt.high_limit = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end

    // Reads return the value held before this cycle's update.
    if (reg_rd_i) begin
      s_nxt.rvalid = 1'b1;
      case (reg_addr_i)
        light_regs_pkg::OFF_SECOND_LOW: begin
          s_nxt.rdata = s_r.second_live.low_word;
        end
        light_regs_pkg::OFF_Q_FIRST_HIGH: begin
          s_nxt.rdata = s_r.q_first.high_word;
        end
        light_regs_pkg::OFF_Q_FIRST_LOW: begin
          s_nxt.rdata = s_r.q_first.low_word;
        end
        light_regs_pkg::OFF_Q_SECOND_HIGH: begin
          s_nxt.rdata = s_r.q_second.high_word;
        end
        light_regs_pkg::OFF_Q_SECOND_LOW: begin
          s_nxt.rdata = s_r.q_second.low_word;
        end
        light_regs_pkg::OFF_LOW_LIMIT: begin
          s_nxt.rdata = s_r.low_limit;
        end
        light_regs_pkg::OFF_HIGH_LIMIT: begin
          s_nxt.rdata = s_r.high_limit;
        end
        default: begin
          s_nxt.rdata = light_regs_pkg::RESULT_RST;
        end
      endcase
    end

    // (RULE15) Compare channel select.
    sel = limit_channel_select_i ? s_r.q_second : s_r.q_first;
    // (RULE14) Exponent as range.
    s_nxt.cmp_range = sel.high_word[15:light_regs_pkg::RANGE_LSB];
    // (RULE3) Mantissa rebuild.
    s_nxt.cmp_mant =
      (20'(sel.high_word[light_regs_pkg::HIGH_MSB:0])
        << light_regs_pkg::MANT_SHIFT) +
      20'(sel.low_word[15:light_regs_pkg::LOW_LSB]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.low_limit <= light_regs_pkg::LOW_LIMIT_RST;
      s_r.high_limit <= light_regs_pkg::HIGH_LIMIT_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o        = s_r.rdata;
  assign reg_rvalid_o       = s_r.rvalid;
  assign low_limit_o        = s_r.low_limit;
  assign high_limit_o       = s_r.high_limit;
  assign compare_range_o    = s_r.cmp_range;
  assign compare_mantissa_o = s_r.cmp_mant;

endmodule

// ### dv/light_regs_monitor.sv
`timescale 1ns/1ps
module light_regs_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic [15:0] low_limit_o,
  input wire logic [15:0] high_limit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd_ok = ce_i & reg_rd_i;
  wire wr_ok = ce_i & reg_wr_i;
  a_read_answer: assert property (rd_ok |=> reg_rvalid_o)
    else $error("read not answered");
  a_no_stray_valid: assert property (!rd_ok |=> !reg_rvalid_o)
    else $error("stray read answer");
  a_reset_values: assert property ($fell(rst_i) |->
    high_limit_o == 16'hBFFF && low_limit_o == 16'h0000)
    else $error("limit reset value wrong");
  a_low_write: assert property (
    wr_ok && reg_addr_i == 4'h8 |=> low_limit_o == $past(reg_wdata_i))
    else $error("low limit write lost");
  a_high_write: assert property (
    wr_ok && reg_addr_i == 4'h9 |=> high_limit_o == $past(reg_wdata_i))
    else $error("high limit write lost");
  a_limits_hold: assert property (
    !(wr_ok && reg_addr_i inside {4'h8, 4'h9})
    |=> $stable(low_limit_o) && $stable(high_limit_o))
    else $error("limit changed without write");
  a_unmapped_zero: assert property (
    rd_ok && !(reg_addr_i inside {[4'h3:4'h9]}) |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_low_readback: assert property (
    rd_ok && reg_addr_i == 4'h8 |=> reg_rdata_o == $past(low_limit_o))
    else $error("low limit readback wrong");
  c_high_write: cover property (wr_ok && reg_addr_i == 4'h9);
  c_unmapped: cover property (rd_ok && reg_addr_i == 4'hF);
  c_queue_read: cover property (rd_ok && reg_addr_i == 4'h7);
  c_frozen_write: cover property (!ce_i && reg_wr_i);
endmodule

// ### dv/reg_host.sv
`timescale 1ns/1ps
module reg_host (
  input  wire logic        clk_i,
  input  wire logic        rvalid_i,
  input  wire logic [15:0] rdata_i,
  output logic      [3:0]  addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [15:0] wdata_o
);
  initial begin
    {addr_o, wr_o, rd_o, wdata_o} = '0;
  end
  // Released lines show inverted values so stale data never looks valid.
  task automatic put(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i) #1;
    {addr_o, wdata_o, wr_o} = {a, v, 1'b1};
    @(posedge clk_i) #1;
    {addr_o, wdata_o, wr_o} = {~a, ~v, 1'b0};
  endtask
  task automatic get(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i) #1;
    {addr_o, rd_o} = {a, 1'b1};
    @(posedge clk_i) #1;
    {addr_o, rd_o} = {~a, 1'b0};
    v = rvalid_i ? rdata_i : 16'hXXXX;
  endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic        ch;
    logic [3:0]  e;
    logic [11:0] h;
    logic [7:0]  l;
  } row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        sel = 1'b0;
  logic        ce = 1'b1;
  logic        done [2] = '{1'b0, 1'b0};
  logic [3:0]  ex [2] = '{4'h0, 4'h0};
  logic [11:0] hi [2] = '{12'h000, 12'h000};
  logic [7:0]  lo [2] = '{8'h00, 8'h00};
  logic [3:0]  cnt [2] = '{4'h0, 4'h0};
  logic [3:0]  addr;
  logic        wr, rd, rvalid;
  logic [15:0] wdata, rdata, lowl, highl, d, q;
  logic [3:0]  crng;
  logic [19:0] cmant;
  int          num_errors = 0;
  int          tests_run = 0;
  row_t        rows [6] = '{'{1'b0, 4'hB, 12'h001, 8'h02},
    '{1'b1, 4'h3, 12'h001, 8'h02}, '{1'b1, 4'hF, 12'hFFF, 8'hFF},
    '{1'b0, 4'h8, 12'hA5A, 8'h5A}, '{1'b0, 4'h0, 12'h000, 8'h00},
    '{1'b1, 4'h5, 12'h123, 8'h80}};
  light_result_fifo_threshold_regs uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .first_done_i(done[0]), .first_range_i(ex[0]),
    .first_high_i(hi[0]), .first_low_i(lo[0]),
    .second_done_i(done[1]), .second_range_i(ex[1]),
    .second_high_i(hi[1]), .second_low_i(lo[1]),
    .limit_channel_select_i(sel), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .low_limit_o(lowl), .high_limit_o(highl),
    .compare_range_o(crng), .compare_mantissa_o(cmant));
  reg_host host (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
    .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  function automatic logic [3:0] chk(input logic [3:0] e,
    input logic [19:0] r, input logic [3:0] c);
    chk[0] = ^{e, r, c};
    chk[1] = ^{c[1], c[3], r & 20'hAAAAA, e[1], e[3]};
    chk[2] = ^{c[3], r & 20'h88888, e[3]};
    chk[3] = ^(r & 20'h80808);
  endfunction
  task automatic cmp(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run_row(input row_t r);
    logic [3:0]  c;
    logic [3:0]  a;
    logic [15:0] w;
    c = cnt[r.ch];
    a = 4'h4 + {2'b00, r.ch, 1'b0};
    w = {r.l, c, chk(r.e, {r.h, r.l}, c)};
    @(posedge clk_i) #1;
    {sel, done[r.ch]} = {r.ch, 1'b1};
    {ex[r.ch], hi[r.ch], lo[r.ch]} = {r.e, r.h, r.l};
    @(posedge clk_i) #1;
    done[r.ch] = 1'b0;
    cnt[r.ch] = c + 4'h1;
    repeat (3) @(posedge clk_i);
    #1;
    cmp(crng, r.e);
    cmp(cmant, {r.h, r.l});
    host.get(a, d);
    cmp(d, {r.e, r.h});
    host.get(a + 4'h1, d);
    cmp(d, w);
    if (r.ch) begin
      host.get(4'h3, d);
      cmp(d, w);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #20000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    // The counter must roll over from F back to 0.
    for (int i = 0; i < 16; i++) run_row(rows[2]);
    host.put(4'h8, 16'h1234);
    host.get(4'h8, d);
    cmp(d, 16'h1234);
    cmp(lowl, 16'h1234);
    host.put(4'h9, 16'h0A5C);
    cmp(highl, 16'h0A5C);
    // With the clock enable low a write must leave the limit alone.
    ce = 1'b0;
    host.put(4'h8, 16'hFFFF);
    cmp(lowl, 16'h1234);
    cmp(rvalid, 1'b0);
    ce = 1'b1;
    host.get(4'h7, q);
    host.put(4'h7, ~q);
    host.get(4'h7, d);
    cmp(d, q);
    host.get(4'hF, d);
    cmp(d, 16'h0000);
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    for (int a = 3; a < 10; a++) begin
      host.get(4'(a), d);
      cmp(d, (a == 9) ? 16'hBFFF : 16'h0000);
    end
    cnt = '{4'h0, 4'h0};
    run_row(rows[1]);
    tally_and_finish();
  end
endmodule
bind light_result_fifo_threshold_regs light_regs_monitor mon (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .low_limit_o(low_limit_o), .high_limit_o(high_limit_o));
